//--- src/ssp_pkg.sv
// Constants and the register map of the serial register port.
// Assumes a single clock domain; all offsets are the 15-bit serial addresses.
package ssp_pkg;

  // ==========================================================================
  // Frame layout and pin filter
  // ==========================================================================
  localparam int          SSP_HEAD_BITS  = 16;
  localparam int          SSP_BYTE_BITS  = 8;
  localparam int          SSP_SYNC_DEPTH = 3;
  localparam logic [14:0] SSP_ADDR_ONE   = 15'h0001;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int SSP_ASC_BIT_HI = 5;
  localparam int SSP_ASC_BIT_LO = 2;
  localparam int SSP_HOLD_BIT   = 0;
  localparam int SSP_ALARM_BITS = 6;

  // ==========================================================================
  // Register kinds and map
  // ==========================================================================
  localparam logic [1:0] SSP_K_RW = 2'h0;
  localparam logic [1:0] SSP_K_RO = 2'h1;
  localparam logic [1:0] SSP_K_WC = 2'h2;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  rst;
    logic [1:0]  kind;
  } ssp_entry_type;

  localparam logic [14:0] SSP_CFG_ADDR   = 15'h0000;
  localparam logic [14:0] SSP_CAT_ADDR   = 15'h0003;
  localparam logic [14:0] SSP_PID_ADDR   = 15'h0004;
  localparam logic [14:0] SSP_MAKL_ADDR  = 15'h000c;
  localparam logic [14:0] SSP_MAKH_ADDR  = 15'h000d;
  localparam logic [14:0] SSP_USER_ADDR  = 15'h0010;
  localparam logic [14:0] SSP_SREF_ADDR  = 15'h002c;
  localparam logic [14:0] SSP_CALST_ADDR = 15'h006a;
  localparam logic [14:0] SSP_LINK_ADDR  = 15'h0208;
  localparam logic [14:0] SSP_ALM_ADDR   = 15'h02c1;

  localparam int SSP_NB      = 52;
  localparam int SSP_CFG_IDX = 0;
  localparam int SSP_USR_IDX = 6;
  localparam int SSP_ALM_IDX = 51;

  // Two-byte registers sit low byte first.  Trim entries hold the fuse default.
  localparam ssp_entry_type SSP_MAP [SSP_NB] = '{
    '{SSP_CFG_ADDR, 8'h30, SSP_K_RW}, '{15'h0002, 8'h00, SSP_K_RW},
    '{SSP_CAT_ADDR, 8'h00, SSP_K_RO}, '{SSP_PID_ADDR, 8'h00, SSP_K_RO},
    '{SSP_MAKL_ADDR, 8'h00, SSP_K_RO}, '{SSP_MAKH_ADDR, 8'h00, SSP_K_RO},
    '{SSP_USER_ADDR, 8'h00, SSP_K_RW}, '{15'h0029, 8'h00, SSP_K_RW},
    '{15'h002a, 8'h00, SSP_K_RW}, '{15'h002b, 8'h11, SSP_K_RW},
    '{SSP_SREF_ADDR, 8'h00, SSP_K_RO}, '{15'h0030, 8'h00, SSP_K_RW},
    '{15'h0031, 8'ha0, SSP_K_RW}, '{15'h0032, 8'h00, SSP_K_RW},
    '{15'h0033, 8'ha0, SSP_K_RW}, '{15'h0038, 8'h00, SSP_K_RW},
    '{15'h003b, 8'h00, SSP_K_RW}, '{15'h0048, 8'h00, SSP_K_RW},
    '{15'h0060, 8'h01, SSP_K_RW}, '{15'h0061, 8'h01, SSP_K_RW},
    '{15'h0062, 8'h01, SSP_K_RW}, '{15'h0064, 8'h02, SSP_K_RW},
    '{15'h0068, 8'h61, SSP_K_RW}, '{SSP_CALST_ADDR, 8'h00, SSP_K_RO},
    '{15'h006b, 8'h00, SSP_K_RW}, '{15'h006c, 8'h01, SSP_K_RW},
    '{15'h006e, 8'h88, SSP_K_RW}, '{15'h0070, 8'h00, SSP_K_RW},
    '{15'h0071, 8'h00, SSP_K_RW}, '{15'h007a, 8'h00, SSP_K_RW},
    '{15'h007b, 8'h00, SSP_K_RW}, '{15'h007c, 8'h00, SSP_K_RW},
    '{15'h007e, 8'h00, SSP_K_RW}, '{15'h007f, 8'h00, SSP_K_RW},
    '{15'h009d, 8'h00, SSP_K_RW}, '{15'h0160, 8'h00, SSP_K_RW},
    '{15'h0200, 8'h01, SSP_K_RW}, '{15'h0201, 8'h02, SSP_K_RW},
    '{15'h0202, 8'h1f, SSP_K_RW}, '{15'h0203, 8'h01, SSP_K_RW},
    '{15'h0204, 8'h03, SSP_K_RW}, '{15'h0205, 8'h00, SSP_K_RW},
    '{15'h0206, 8'h00, SSP_K_RW}, '{15'h0207, 8'h00, SSP_K_RW},
    '{SSP_LINK_ADDR, 8'h00, SSP_K_RO}, '{15'h0209, 8'h00, SSP_K_RW},
    '{15'h020a, 8'h00, SSP_K_RW}, '{15'h020b, 8'h00, SSP_K_RW},
    '{15'h020f, 8'h00, SSP_K_RW}, '{15'h0210, 8'h00, SSP_K_RW},
    '{15'h0211, 8'hf2, SSP_K_RW}, '{SSP_ALM_ADDR, 8'h3f, SSP_K_WC}
  };

  typedef enum logic [1:0] {
    SSP_ST_IDLE,
    SSP_ST_HEAD,
    SSP_ST_DATA
  } ssp_state_type;

endpackage

//--- src/ssp_serial_port.sv
// Serial register port: 24-bit frames with streaming, plus the register file.
// Assumes the serial pins are asynchronous to clock_in and that the serial
// clock is much slower than clock_in (at least four system cycles per phase).
`timescale 1ns/1ps

module ssp_serial_port
  import ssp_pkg::*;
#(
  parameter logic [7:0]  PART_CATEGORY = 8'h5a,
  parameter logic [7:0]  PART_ID       = 8'h21,
  parameter logic [15:0] MAKER_ID      = 16'h1234
) (
  input  wire logic                      clock_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      port_select_n_in,
  input  wire logic                      port_clk_in,
  input  wire logic                      port_data_in_in,
  input  wire logic [7:0]                sysref_capture_position_in,
  input  wire logic [7:0]                cal_state_in,
  input  wire logic [7:0]                link_status_in,
  input  wire logic [SSP_ALARM_BITS-1:0] alarm_set_in,
  output logic                           port_data_out_out,
  output logic                           port_data_out_oe_out,
  output logic [SSP_ALARM_BITS-1:0]      alarm_flags_out
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Bit 0 select, bit 1 clock, bit 2 data.  A level is believed only when the
  // second and third stages agree, which also rejects a single-cycle glitch.
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] filt_r;
  logic [2:0] filt_nxt;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      sync3_r <= 3'h7;
    end else begin
      sync1_r <= {port_data_in_in, port_clk_in, port_select_n_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_comb begin
    for (int b = 0; b < SSP_SYNC_DEPTH; b++) begin
      filt_nxt[b] = (sync2_r[b] == sync3_r[b]) ? sync3_r[b] : filt_r[b];
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      filt_r <= 3'h7;
    end else begin
      filt_r <= filt_nxt;
    end
  end

  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sdi_bit;

  assign sel_fall = filt_r[0] && !filt_nxt[0];
  assign sel_rise = !filt_r[0] && filt_nxt[0];
  assign sck_rise = !filt_r[1] && filt_nxt[1] && !filt_nxt[0];
  assign sdi_bit  = filt_nxt[2];

  // ==========================================================================
  // Frame sequencer
  // ==========================================================================
  ssp_state_type state_r;
  logic [4:0]    cnt_r;
  logic [14:0]   shift_r;
  logic          read_r;
  logic [14:0]   addr_r;
  logic [14:0]   addr_nxt;
  logic [7:0]    mem_r [SSP_NB];
  logic          byte_done;
  logic          head_done;
  logic          wr_fire;
  logic [7:0]    wr_data;
  logic          load_r;
  logic          step_up;
  logic          step_hold;

  // Mirrored direction bits: either one set selects ascending.
  assign step_up   = mem_r[SSP_CFG_IDX][SSP_ASC_BIT_HI]
                   | mem_r[SSP_CFG_IDX][SSP_ASC_BIT_LO];
  assign step_hold = mem_r[SSP_USR_IDX][SSP_HOLD_BIT];

  assign head_done = (state_r == SSP_ST_HEAD) && sck_rise
                   && (cnt_r == 5'(SSP_HEAD_BITS - 1));
  assign byte_done = (state_r == SSP_ST_DATA) && sck_rise
                   && (cnt_r == 5'(SSP_BYTE_BITS - 1));
  // Only a write frame stores, and only once its whole byte has arrived.
  assign wr_fire   = byte_done && !read_r;
  assign wr_data   = {shift_r[6:0], sdi_bit};

  always_comb begin
    if (step_hold) begin
      addr_nxt = addr_r;
    end else if (step_up) begin
      addr_nxt = addr_r + SSP_ADDR_ONE;
    end else begin
      addr_nxt = addr_r - SSP_ADDR_ONE;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= SSP_ST_IDLE;
      cnt_r   <= 5'h00;
      shift_r <= 15'h0000;
      read_r  <= 1'b0;
      addr_r  <= 15'h0000;
    end else if (sel_rise || filt_nxt[0]) begin
      state_r <= SSP_ST_IDLE;
      cnt_r   <= 5'h00;
    end else if (sel_fall) begin
      state_r <= SSP_ST_HEAD;
      cnt_r   <= 5'h00;
    end else if (sck_rise) begin
      unique case (state_r)
        SSP_ST_IDLE: begin
          cnt_r <= 5'h00;
        end
        SSP_ST_HEAD: begin
          shift_r <= {shift_r[13:0], sdi_bit};
          cnt_r   <= cnt_r + 5'h01;
          if (head_done) begin
            read_r  <= shift_r[14];
            addr_r  <= {shift_r[13:0], sdi_bit};
            state_r <= SSP_ST_DATA;
            cnt_r   <= 5'h00;
          end
        end
        SSP_ST_DATA: begin
          shift_r <= {shift_r[13:0], sdi_bit};
          cnt_r   <= cnt_r + 5'h01;
          if (byte_done) begin
            cnt_r  <= 5'h00;
            addr_r <= addr_nxt;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Read path and data out
  // ==========================================================================
  logic [7:0] rd_byte;
  logic [7:0] out_r;

  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < SSP_NB; i++) begin
      if (SSP_MAP[i].addr == addr_r) begin
        rd_byte = mem_r[i];
      end
    end
  end

  // The byte to return is fetched one cycle after the address settles.
  // At the end of the header the direction flag is still that of the last
  // frame, so the direction bit is taken straight from the shifter there.
  // Fetching late also lets a streamed read see the address stepped after the last byte.
  logic read_now;

  assign read_now = head_done ? shift_r[14] : read_r;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      load_r <= 1'b0;
    end else begin
      load_r <= !filt_nxt[0] && read_now && (head_done || byte_done) && !sel_rise;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_r                <= 8'h00;
      port_data_out_out    <= 1'b0;
      port_data_out_oe_out <= 1'b0;
    end else if (filt_nxt[0] || state_r != SSP_ST_DATA || !read_r) begin
      port_data_out_oe_out <= 1'b0;
      port_data_out_out    <= 1'b0;
    end else if (load_r) begin
      out_r                <= {rd_byte[6:0], 1'b0};
      port_data_out_out    <= rd_byte[7];
      port_data_out_oe_out <= 1'b1;
    end else if (sck_rise && !byte_done) begin
      out_r             <= {out_r[6:0], 1'b0};
      port_data_out_out <= out_r[7];
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  // Read-only entries follow their source every cycle; writes to them drop.
  for (genvar i = 0; i < SSP_NB; i++) begin : g_reg
    if (SSP_MAP[i].kind == SSP_K_RW) begin : g_rw
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          mem_r[i] <= SSP_MAP[i].rst;
        end else if (wr_fire && addr_r == SSP_MAP[i].addr) begin
          mem_r[i] <= wr_data;
        end
      end
    end else if (SSP_MAP[i].kind == SSP_K_WC) begin : g_wc
      // A new alarm in the cycle of a clearing write still sets its flag.
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          mem_r[i] <= SSP_MAP[i].rst;
        end else if (wr_fire && addr_r == SSP_MAP[i].addr) begin
          mem_r[i] <= (mem_r[i] & ~wr_data) | {2'h0, alarm_set_in};
        end else begin
          mem_r[i] <= mem_r[i] | {2'h0, alarm_set_in};
        end
      end
    end else begin : g_ro
      logic [7:0] src;
      always_comb begin
        unique case (SSP_MAP[i].addr)
          SSP_CAT_ADDR:   src = PART_CATEGORY;
          SSP_PID_ADDR:   src = PART_ID;
          SSP_MAKL_ADDR:  src = MAKER_ID[7:0];
          SSP_MAKH_ADDR:  src = MAKER_ID[15:8];
          SSP_SREF_ADDR:  src = sysref_capture_position_in;
          SSP_CALST_ADDR: src = cal_state_in;
          SSP_LINK_ADDR:  src = link_status_in;
          default:        src = 8'h00;
        endcase
      end
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          mem_r[i] <= SSP_MAP[i].rst;
        end else begin
          mem_r[i] <= src;
        end
      end
    end
  end

  assign alarm_flags_out = mem_r[SSP_ALM_IDX][SSP_ALARM_BITS-1:0];

endmodule

//--- testbench/ssp_checker_properties.sv
// Timing checks on the serial register port, seen from its top-level ports.
// Assumes the host moves serial pins just after clock_in edges.
`timescale 1ns/1ps

module ssp_checker
  import ssp_pkg::*;
(
  input wire logic                      clock_in,
  input wire logic                      sys_rst_in,
  input wire logic                      port_select_n_in,
  input wire logic                      port_clk_in,
  input wire logic                      port_data_in_in,
  input wire logic [7:0]                sysref_capture_position_in,
  input wire logic [7:0]                cal_state_in,
  input wire logic [7:0]                link_status_in,
  input wire logic [SSP_ALARM_BITS-1:0] alarm_set_in,
  input wire logic                      port_data_out_out,
  input wire logic                      port_data_out_oe_out,
  input wire logic [SSP_ALARM_BITS-1:0] alarm_flags_out
);
  // ==========================================================================
  // Frame tracking on the raw pins
  // ==========================================================================
  logic [6:0] cnt_r;
  logic [3:0] since_r;
  logic       rd_r;
  logic       clk_q_r;
  wire        rise = port_clk_in && !clk_q_r && !port_select_n_in;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r   <= '0;
      rd_r    <= 1'b0;
      clk_q_r <= 1'b0;
      since_r <= 4'hf;
    end else begin
      clk_q_r <= port_clk_in;
      if (port_select_n_in) begin
        cnt_r <= '0;
        rd_r  <= 1'b0;
      end else if (rise) begin
        cnt_r <= cnt_r + 7'h01;
        if (cnt_r == 7'h00) begin
          rd_r <= port_data_in_in;
        end
      end
      if (rise) begin
        since_r <= 4'h0;
      end else if (since_r != 4'hf) begin
        since_r <= since_r + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_release;
    $rose(port_select_n_in) ##1 port_select_n_in [*6];
  endsequence
  sequence s_read_head;
    rd_r && !port_select_n_in && $rose(cnt_r == 7'h10);
  endsequence

  property p_release; s_release |-> !port_data_out_oe_out; endproperty
  property p_quiet; !port_data_out_oe_out |-> !port_data_out_out; endproperty
  property p_oe_head;
    (port_data_out_oe_out && !port_select_n_in) |-> (rd_r && cnt_r >= 7'h10);
  endproperty
  property p_read_oe; s_read_head |-> ##[2:8] port_data_out_oe_out; endproperty
  property p_bit_time;
    (port_data_out_oe_out && $past(port_data_out_oe_out) && $changed(port_data_out_out))
      |-> (since_r >= 4'h1 && since_r <= 4'h7);
  endproperty
  property p_set;
    (|alarm_set_in) |=> ((alarm_flags_out & $past(alarm_set_in)) == $past(alarm_set_in));
  endproperty
  property p_clear;
    (|($past(alarm_flags_out) & ~alarm_flags_out))
      |-> (!rd_r && cnt_r >= 7'h18 && !port_select_n_in);
  endproperty
  property p_rst;
    $fell(sys_rst_in) |-> (alarm_flags_out == 6'h3f && !port_data_out_oe_out);
  endproperty

  a_release: assert property (p_release)
    else $error("data out driven after select release");
  a_quiet: assert property (p_quiet)
    else $error("data out not low while released");
  a_oe_head: assert property (p_oe_head)
    else $error("data out driven outside read data phase");
  a_read_oe: assert property (p_read_oe)
    else $error("read data not driven after header");
  a_bit_time: assert property (p_bit_time)
    else $error("read bit changed away from serial rise");
  a_set: assert property (p_set)
    else $error("alarm event did not set flag");
  a_clear: assert property (p_clear)
    else $error("alarm flag cleared without write");
  a_rst: assert property (p_rst)
    else $error("wrong state after reset");
endmodule

bind ssp_serial_port ssp_checker i_ssp_checker (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .port_select_n_in(port_select_n_in),
  .port_clk_in(port_clk_in), .port_data_in_in(port_data_in_in),
  .sysref_capture_position_in(sysref_capture_position_in), .cal_state_in(cal_state_in),
  .link_status_in(link_status_in), .alarm_set_in(alarm_set_in),
  .port_data_out_out(port_data_out_out), .port_data_out_oe_out(port_data_out_oe_out),
  .alarm_flags_out(alarm_flags_out)
);

//--- testbench/ssp_host_model.sv
// Host serial controller model: frames, streaming bytes, aborted frames.
// Assumes a serial clock of eight clock_in periods, idle low between frames.
`timescale 1ns/1ps

module ssp_host_model (
  input  wire logic clock_in,
  input  wire logic sdo_in,
  output logic      select_n_out,
  output logic      sclk_out,
  output logic      sdi_out
);
  // The model never starts a calibration, so no access overlaps one.
  initial begin
    select_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end

  task automatic open_frame;
    @(posedge clock_in);
    select_n_out <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask

  // Bits go out most significant first; read bits are taken at the rise.
  task automatic shift(input logic [7:0] w, input int nb, output logic [7:0] r);
    r = '0;
    for (int i = 7; i > 7 - nb; i--) begin
      sclk_out <= 1'b0;
      sdi_out <= w[i];
      repeat (4) @(posedge clock_in);
      sclk_out <= 1'b1;
      r[i] = sdo_in;
      repeat (4) @(posedge clock_in);
    end
  endtask

  // Data in is left toggled afterwards, so a stale bit is never mistaken.
  task automatic close_frame;
    repeat (8) @(posedge clock_in);
    sclk_out <= 1'b0;
    select_n_out <= 1'b1;
    sdi_out <= ~sdi_out;
    repeat (8) @(posedge clock_in);
  endtask

  task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                      input logic [31:0] w, output logic [31:0] r);
    logic [7:0] b;
    r = '0;
    open_frame();
    shift({rd, a[14:8]}, 8, b);
    shift(a[7:0], 8, b);
    for (int k = 0; k < n; k++) begin
      shift(w[31-8*k -: 8], 8, b);
      r[31-8*k -: 8] = b;
    end
    close_frame();
  endtask
endmodule

//--- testbench/tb_ssp_serial_port.sv
// Self-checking bench for the serial register port.
// Assumes the host model in ssp_host_model and the bound checker.
`timescale 1ns/1ps

module tb_ssp_serial_port;
  import ssp_pkg::*;
  logic                      clock_in;
  logic                      sys_rst_in;
  logic                      sel_n;
  logic                      sclk;
  logic                      port_data_in;
  logic [7:0]                sysref_capture_position_in;
  logic [7:0]                cal_state_in;
  logic [7:0]                link_status_in;
  logic [SSP_ALARM_BITS-1:0] alarm_set_in;
  logic                      dout;
  logic                      oe;
  logic [SSP_ALARM_BITS-1:0] flags;
  logic [31:0]               rv;
  logic [7:0]                junk;
  int                        n_mismatch;
  int                        n_tests;
  wire                       port_data_out = oe ? dout : 1'bz;
  logic [14:0] ra [13] = '{15'h000, 15'h02b, 15'h031, 15'h068, 15'h06e, 15'h202, 15'h211,
                           15'h003, 15'h00d, 15'h001, 15'h02c, 15'h06a, 15'h208};
  logic [7:0]  rx [13] = '{8'h30, 8'h11, 8'ha0, 8'h61, 8'h88, 8'h1f, 8'hf2,
                           8'h3c, 8'hbe, 8'h00, 8'h5c, 8'ha3, 8'h7e};

  // Identity values are arbitrary.
  ssp_serial_port #(.PART_CATEGORY(8'h3c), .PART_ID(8'h47), .MAKER_ID(16'hbeef))
  i_ssp_serial_port (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .port_select_n_in(sel_n),
    .port_clk_in(sclk), .port_data_in_in(port_data_in), .sysref_capture_position_in(sysref_capture_position_in),
    .cal_state_in(cal_state_in), .link_status_in(link_status_in),
    .alarm_set_in(alarm_set_in), .port_data_out_out(dout),
    .port_data_out_oe_out(oe), .alarm_flags_out(flags)
  );
  ssp_host_model i_ssp_host_model (
    .clock_in(clock_in), .sdo_in(port_data_out), .select_n_out(sel_n), .sclk_out(sclk), .sdi_out(port_data_in)
  );

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] w);
    i_ssp_host_model.xfer(1'b0, a, n, w, rv);
  endtask
  task automatic rd(input logic [14:0] a, input int n, input logic [31:0] exp);
    i_ssp_host_model.xfer(1'b1, a, n, 32'h0, rv);
    check($sformatf("reg %h", a), exp, rv);
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  initial begin
    repeat (40000) @(posedge clock_in);
    n_mismatch++;
    finish_test();
  end

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    sys_rst_in = 1'b1;
    alarm_set_in = '0;
    sysref_capture_position_in = 8'h5c;
    cal_state_in = 8'ha3;
    link_status_in = 8'h7e;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    check("alarm flags", 32'h3f, {26'h0, flags});
    for (int k = 0; k < 13; k++) rd(ra[k], 1, {rx[k], 24'h0});
    wr(15'h029, 3, 32'h11223300);
    rd(15'h029, 3, 32'h11223300);
    rd(15'h030, 2, 32'h00a00000);
    wr(15'h003, 1, 32'hff000000);
    wr(15'h004, 1, 32'h77000000);
    rd(15'h003, 2, 32'h3c470000);
    rd(15'h001, 1, 32'h0);
    wr(15'h000, 1, 32'h0);
    wr(15'h062, 2, 32'h44550000);
    rd(15'h062, 2, 32'h44550000);
    wr(15'h000, 1, 32'h04000000);
    rd(15'h061, 2, 32'h55440000);
    wr(15'h010, 1, 32'h01000000);
    wr(15'h060, 2, 32'h66770000);
    rd(15'h060, 2, 32'h77770000);
    wr(15'h010, 1, 32'h0);
    rd(15'h060, 2, 32'h77550000);
    // A frame dropped in its data byte must leave the register alone.
    i_ssp_host_model.open_frame();
    i_ssp_host_model.shift(8'h00, 8, junk);
    i_ssp_host_model.shift(8'h30, 8, junk);
    i_ssp_host_model.shift(8'hff, 4, junk);
    i_ssp_host_model.close_frame();
    rd(15'h030, 1, 32'h0);
    wr(15'h2c1, 1, 32'h3f000000);
    check("alarm cleared", 32'h0, {26'h0, flags});
    alarm_set_in <= 6'h04;
    @(posedge clock_in);
    alarm_set_in <= 6'h00;
    repeat (2) @(posedge clock_in);
    rd(15'h2c1, 1, 32'h04000000);
    finish_test();
  end
endmodule
